// ==== hdl/bcs_pkg.sv ====
package bcs_pkg;

    // Op code word layout
    localparam int          OPW          = 16;
    localparam int          OP_CC_LSB    = 0;
    localparam int          OP_INV_BIT   = 4;
    localparam int          OP_SIG_LSB   = 5;
    localparam int          OP_CODE_LSB  = 10;
    localparam logic [4:0]  OP_SIGNATURE = 5'h0a;
    localparam logic [15:0] CC_INV_MASK  = 16'h9103;

    // Op code field values
    localparam logic [4:0] OPC_HALT = 5'h00;
    localparam logic [4:0] OPC_JUMP = 5'h01;
    localparam logic [4:0] OPC_CALL = 5'h02;
    localparam logic [4:0] OPC_RTN  = 5'h03;
    localparam logic [4:0] OPC_IRQ  = 5'h04;
    localparam logic [4:0] OPC_FLAG = 5'h05;
    localparam logic [4:0] OPC_FLIP = 5'h06;
    localparam logic [4:0] OPC_PTT  = 5'h07;
    localparam logic [4:0] OPC_PBS  = 5'h08;
    localparam logic [4:0] OPC_PIMM = 5'h09;
    localparam logic [4:0] OPC_PMEM = 5'h0a;
    localparam logic [4:0] OPC_DLY  = 5'h0b;
    localparam logic [4:0] OPC_SFRM = 5'h0c;
    localparam logic [4:0] OPC_WTRG = 5'h0d;
    localparam logic [4:0] OPC_CMPF = 5'h0e;
    localparam logic [4:0] OPC_CMPN = 5'h0f;
    localparam logic [4:0] OPC_LTT  = 5'h10;
    localparam logic [4:0] OPC_LFT  = 5'h11;
    localparam logic [4:0] OPC_LAST = 5'h11;

    // Pointer toggle of the execute-and-flip op
    localparam logic [15:0] FLIP_MASK = 16'h0010;

    // Call stack and queue
    localparam int         STACK_DEPTH = 4;
    localparam logic [5:0] QUEUE_WRAP  = 6'h3f;

    // APB register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_START  = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_EN = 8'h0c;
    localparam logic [7:0] REG_INT_ST = 8'h10;
    localparam logic [7:0] REG_FLAGS  = 8'h14;
    localparam logic [7:0] REG_QPTR   = 8'h18;

    // Interrupt bit positions
    localparam int INT_TRAP   = 0;
    localparam int INT_PARITY = 1;
    localparam int INT_STACK  = 2;
    localparam int INT_QROLL  = 3;
    localparam int INT_USER   = 4;
    localparam int INT_W      = 5;

    // Reset values
    localparam logic [15:0] START_RST = 16'h0000;
    localparam logic [15:0] QPTR_RST  = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_OP_RD,
        ST_PRM_RD,
        ST_EXEC,
        ST_MSG_WAIT,
        ST_FLIP_CHK,
        ST_MEM_WR,
        ST_PUSH_RD,
        ST_DELAY,
        ST_TRIG_WAIT,
        ST_HALT
    } bcs_state_t;

endpackage : bcs_pkg

// ==== hdl/bcs_cond_eval.sv ====
`timescale 1ns/10ps
`default_nettype none

module bcs_cond_eval
    import bcs_pkg::*;
(
    // Op code word and raw condition codes
    input  wire logic [15:0] op_in,
    input  wire logic [15:0] cc_in,
    // Results
    output logic             cond_true_out,
    output logic             parity_ok_out,
    output logic             op_ok_out
);

    logic [3:0] sel;
    logic [4:0] opc;

    always_comb
    begin
        sel           = op_in[OP_CC_LSB +: 4];
        opc           = op_in[OP_CODE_LSB +: 5];
        // Only some codes have a distinct inverse
        cond_true_out = cc_in[sel] ^ (op_in[OP_INV_BIT] & CC_INV_MASK[sel]);
        parity_ok_out = ^op_in;
        op_ok_out     = parity_ok_out
                      && (op_in[OP_SIG_LSB +: 5] == OP_SIGNATURE)
                      && (opc <= OPC_LAST);
    end

endmodule : bcs_cond_eval

`default_nettype wire

// ==== hdl/bcs_engine.sv ====
// Summary of operation
// - Bad-message code is format error, loop fail or no response; status set ignored.
// - Retry codes bits 14,13: 00 none, 01 one, 11 two.
// - Code 15 is always true; inverse bit makes it never true.
// - Four-entry call stack with call, jump and return.
// - Stack overrun or underrun raises stack error interrupt when enabled.
// - Host-interrupt op posts a 4-bit vector in the status register and sets the user interrupt when enabled.
// - Flag op sets, clears or toggles any of eight flags.
// - Undefined, even parity or bad 01010 signature halts at once.
// - Invalid op code halt raises trap interrupt when enabled.
// - Parity failure also raises parity interrupt when enabled.
// - Execute-and-flip always runs its message, then tests its condition.
// - True condition rewrites the pointer in memory as old XOR 0010h.
// - Next pass of that line uses the flipped block address.
// - Push ops queue time tag, block status, immediate or memory word.
// - Queue pointer holds next write slot, wrapping modulo 64.
// - Queue pointer rollover at 64 words raises interrupt when enabled.
// - Delay, frame start, trigger wait, compares, time loads and halt.
// - Codes 0 and 1 hold less-than and equal of last compare.
// - Host sets, clears or toggles flags like the flag op.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module bcs_engine
    import bcs_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK_IN,
    input  wire logic        RSTN_IN,
    // APB slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // Shared RAM port
    output logic             MEM_REQ_OUT,
    output logic             MEM_WE_OUT,
    output logic [15:0]      MEM_ADDR_OUT,
    output logic [15:0]      MEM_WDATA_OUT,
    input  wire logic [15:0] MEM_RDATA_IN,
    input  wire logic        MEM_ACK_IN,
    // Message processor
    output logic             MSG_START_OUT,
    output logic [15:0]      MSG_PTR_OUT,
    input  wire logic        MSG_DONE_IN,
    input  wire logic        MSG_FMT_ERR_IN,
    input  wire logic        MSG_LOOP_FAIL_IN,
    input  wire logic        MSG_NORESP_IN,
    input  wire logic        MSG_GOOD_BLK_IN,
    input  wire logic        MSG_MASKED_IN,
    input  wire logic [1:0]  MSG_RETRIES_IN,
    input  wire logic [15:0] MSG_BLK_STATUS_IN,
    // Timers and trigger
    input  wire logic [15:0] TIME_TAG_IN,
    input  wire logic [15:0] FRAME_TIME_IN,
    input  wire logic [15:0] NEXT_MSG_TIME_IN,
    input  wire logic        EXT_TRIG_IN,
    output logic             TIME_TAG_LOAD_OUT,
    output logic             FRAME_TIME_LOAD_OUT,
    output logic             FRAME_START_OUT,
    // Status
    output logic             HALTED_OUT,
    output logic             IRQ_OUT
);

    typedef struct packed {
        bcs_state_t        st;
        logic [15:0]       pc;
        logic [15:0]       op;
        logic [15:0]       prm;
        logic [15:0]       start;
        logic [15:0]       qptr;
        logic [15:0]       cnt;
        logic [7:0]        gp;
        logic              fmt;
        logic              loop;
        logic              noresp;
        logic              gdblk;
        logic              masked;
        logic [1:0]        retry;
        logic [15:0]       bsw;
        logic [3:0][15:0]  stk;
        logic [2:0]        sp;
        logic              push;
        logic [INT_W-1:0]  int_en;
        logic [INT_W-1:0]  int_st;
        logic [3:0]        vec;
        logic              mem_req;
        logic              mem_we;
        logic [15:0]       mem_addr;
        logic [15:0]       mem_wdata;
        logic              msg_start;
        logic              tt_load;
        logic              ft_load;
        logic              frm_start;
        logic              halted;
        logic              irq;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } bcs_regs_t;

    bcs_regs_t        r_q;
    bcs_regs_t        r_d;
    logic [15:0]      cc;
    logic             cond_true;
    logic             parity_ok;
    logic             op_ok;
    logic [15:0]      op_view;
    logic [INT_W-1:0] ev;
    logic             apb_wr;
    logic             apb_rd;
    logic [15:0]      cmp_val;

    // Flags first, then message outcome codes
    assign cc = {1'b1, r_q.retry, r_q.fmt | r_q.loop | r_q.noresp,
                 r_q.masked, r_q.gdblk, r_q.fmt, r_q.noresp, r_q.gp};
    // Check the word as it arrives so a bad one never executes
    assign op_view = (r_q.st == ST_OP_RD) ? MEM_RDATA_IN : r_q.op;

    bcs_cond_eval u_cond (
        .op_in         (op_view),
        .cc_in         (cc),
        .cond_true_out (cond_true),
        .parity_ok_out (parity_ok),
        .op_ok_out     (op_ok)
    );

    function automatic logic [7:0] flag_upd(input logic [7:0]  f,
                                            input logic [15:0] v);
        logic [7:0] s;
        logic [7:0] c;
        s = v[7:0];
        c = v[15:8];
        // Set and clear together toggle
        flag_upd = (f & ~(s | c)) | (s & ~c) | (~f & s & c);
    endfunction : flag_upd

    always_comb
    begin
        r_d           = r_q;
        ev            = '0;
        r_d.msg_start = 1'b0;
        r_d.tt_load   = 1'b0;
        r_d.ft_load   = 1'b0;
        r_d.frm_start = 1'b0;
        apb_wr        = PSEL_IN && PENABLE_IN && PWRITE_IN && !r_q.pready;
        apb_rd        = PSEL_IN && PENABLE_IN && !PWRITE_IN && !r_q.pready;
        cmp_val       = (r_q.op[OP_CODE_LSB +: 5] == OPC_CMPF)
                      ? FRAME_TIME_IN : NEXT_MSG_TIME_IN;

        // APB: answer in the second access cycle
        r_d.pready  = PSEL_IN && PENABLE_IN && !r_q.pready;
        r_d.pslverr = 1'b0;
        r_d.prdata  = '0;
        if (apb_wr || apb_rd)
        begin
            case (PADDR_IN)
                REG_CTRL:   ;
                REG_START:  r_d.prdata = {16'h0000, r_q.start};
                REG_STATUS: r_d.prdata = {16'h0000, r_q.halted, r_q.sp,
                                          r_q.vec, 4'(r_q.st), 4'h0};
                REG_INT_EN: r_d.prdata = {27'h0, r_q.int_en};
                REG_INT_ST: r_d.prdata = {27'h0, r_q.int_st};
                REG_FLAGS:  r_d.prdata = {24'h0, r_q.gp};
                REG_QPTR:   r_d.prdata = {16'h0000, r_q.qptr};
                default:    r_d.pslverr = 1'b1;
            endcase
        end
        if (apb_wr)
        begin
            case (PADDR_IN)
                REG_START:  r_d.start  = PWDATA_IN[15:0];
                REG_INT_EN: r_d.int_en = PWDATA_IN[INT_W-1:0];
                REG_INT_ST: r_d.int_st = r_q.int_st & ~PWDATA_IN[INT_W-1:0];
                REG_FLAGS:  r_d.gp     = flag_upd(r_q.gp, PWDATA_IN[15:0]);
                REG_QPTR:   r_d.qptr   = PWDATA_IN[15:0];
                default:    ;
            endcase
        end

        case (r_q.st)
            ST_IDLE, ST_HALT: ;
            ST_OP_RD:
                if (MEM_ACK_IN)
                begin
                    r_d.op = MEM_RDATA_IN;
                    if (!op_ok)
                    begin
                        r_d.mem_req      = 1'b0;
                        r_d.st           = ST_HALT;
                        ev[INT_TRAP]     = 1'b1;
                        ev[INT_PARITY]   = !parity_ok;
                    end
                    else
                    begin
                        r_d.mem_addr = r_q.pc + 16'h0001;
                        r_d.st       = ST_PRM_RD;
                    end
                end
            ST_PRM_RD:
                if (MEM_ACK_IN)
                begin
                    r_d.mem_req = 1'b0;
                    r_d.prm     = MEM_RDATA_IN;
                    r_d.st      = ST_EXEC;
                end
            ST_EXEC:
            begin
                r_d.pc = r_q.pc + 16'h0002;
                r_d.st = ST_OP_RD;
                if (r_q.op[OP_CODE_LSB +: 5] == OPC_FLIP)
                begin
                    r_d.msg_start = 1'b1;
                    r_d.pc        = r_q.pc;
                    r_d.st        = ST_MSG_WAIT;
                end
                else if (cond_true)
                begin
                    case (r_q.op[OP_CODE_LSB +: 5])
                        OPC_HALT: r_d.st = ST_HALT;
                        OPC_JUMP: r_d.pc = r_q.prm;
                        OPC_CALL:
                            if (r_q.sp == 3'(STACK_DEPTH))
                                ev[INT_STACK] = 1'b1;
                            else
                            begin
                                r_d.stk[r_q.sp[1:0]] = r_q.pc + 16'h0002;
                                r_d.sp = r_q.sp + 3'h1;
                                r_d.pc = r_q.prm;
                            end
                        OPC_RTN:
                            if (r_q.sp == 3'h0)
                                ev[INT_STACK] = 1'b1;
                            else
                            begin
                                r_d.pc = r_q.stk[r_q.sp[1:0] - 2'h1];
                                r_d.sp = r_q.sp - 3'h1;
                            end
                        OPC_IRQ:
                        begin
                            r_d.vec        = r_q.prm[3:0];
                            ev[INT_USER]   = 1'b1;
                        end
                        OPC_FLAG: r_d.gp = flag_upd(r_q.gp, r_q.prm);
                        OPC_PTT, OPC_PBS, OPC_PIMM:
                        begin
                            r_d.mem_wdata = (r_q.op[OP_CODE_LSB +: 5] == OPC_PTT)
                                          ? TIME_TAG_IN
                                          : (r_q.op[OP_CODE_LSB +: 5] == OPC_PBS)
                                          ? r_q.bsw : r_q.prm;
                            r_d.push      = 1'b1;
                            r_d.st        = ST_MEM_WR;
                        end
                        OPC_PMEM: r_d.st = ST_PUSH_RD;
                        OPC_DLY:
                        begin
                            r_d.cnt = r_q.prm;
                            r_d.st  = ST_DELAY;
                        end
                        OPC_SFRM: r_d.frm_start = 1'b1;
                        OPC_WTRG: r_d.st = ST_TRIG_WAIT;
                        OPC_CMPF, OPC_CMPN:
                        begin
                            r_d.gp[0] = cmp_val < r_q.prm;
                            r_d.gp[1] = cmp_val == r_q.prm;
                        end
                        OPC_LTT: r_d.tt_load = 1'b1;
                        OPC_LFT: r_d.ft_load = 1'b1;
                        default: ;
                    endcase
                end
                // Fetch or memory access for the next state
                r_d.mem_req  = (r_d.st == ST_OP_RD) || (r_d.st == ST_MEM_WR)
                            || (r_d.st == ST_PUSH_RD);
                r_d.mem_we   = (r_d.st == ST_MEM_WR);
                r_d.mem_addr = (r_d.st == ST_PUSH_RD) ? r_q.prm
                             : (r_d.st == ST_MEM_WR) ? r_q.qptr : r_d.pc;
            end
            ST_MSG_WAIT:
                if (MSG_DONE_IN)
                begin
                    r_d.fmt    = MSG_FMT_ERR_IN;
                    r_d.loop   = MSG_LOOP_FAIL_IN;
                    r_d.noresp = MSG_NORESP_IN;
                    r_d.gdblk  = MSG_GOOD_BLK_IN;
                    r_d.masked = MSG_MASKED_IN;
                    r_d.bsw    = MSG_BLK_STATUS_IN;
                    r_d.retry  = (MSG_RETRIES_IN == 2'h0) ? 2'b00
                               : (MSG_RETRIES_IN == 2'h1) ? 2'b01 : 2'b11;
                    r_d.st     = ST_FLIP_CHK;
                end
            ST_FLIP_CHK:
            begin
                // Condition sees the outcome of the message just run
                r_d.mem_req = 1'b1;
                if (cond_true)
                begin
                    r_d.mem_we    = 1'b1;
                    r_d.mem_addr  = r_q.pc + 16'h0001;
                    r_d.mem_wdata = r_q.prm ^ FLIP_MASK;
                    r_d.push      = 1'b0;
                    r_d.st        = ST_MEM_WR;
                end
                else
                begin
                    r_d.pc       = r_q.pc + 16'h0002;
                    r_d.mem_addr = r_q.pc + 16'h0002;
                    r_d.st       = ST_OP_RD;
                end
            end
            ST_PUSH_RD:
                if (MEM_ACK_IN)
                begin
                    r_d.mem_we    = 1'b1;
                    r_d.mem_addr  = r_q.qptr;
                    r_d.mem_wdata = MEM_RDATA_IN;
                    r_d.push      = 1'b1;
                    r_d.st        = ST_MEM_WR;
                end
            ST_MEM_WR:
                if (MEM_ACK_IN)
                begin
                    if (r_q.push)
                    begin
                        r_d.qptr = {r_q.qptr[15:6], r_q.qptr[5:0] + 6'h01};
                        ev[INT_QROLL] = (r_q.qptr[5:0] == QUEUE_WRAP);
                    end
                    r_d.push     = 1'b0;
                    r_d.mem_we   = 1'b0;
                    r_d.pc       = r_q.pc + 16'h0002;
                    r_d.mem_addr = r_q.pc + 16'h0002;
                    r_d.st       = ST_OP_RD;
                end
            ST_DELAY, ST_TRIG_WAIT:
                if ((r_q.st == ST_DELAY) ? (r_q.cnt == 16'h0000) : EXT_TRIG_IN)
                begin
                    r_d.frm_start = (r_q.st == ST_TRIG_WAIT);
                    r_d.mem_req   = 1'b1;
                    r_d.mem_addr  = r_q.pc;
                    r_d.st        = ST_OP_RD;
                end
                else
                    r_d.cnt = r_q.cnt - 16'h0001;
            default: r_d.st = ST_HALT;
        endcase

        // Host control: bit 0 restarts, bit 1 stops
        if (apb_wr && PADDR_IN == REG_CTRL && (PWDATA_IN[0] || PWDATA_IN[1]))
        begin
            r_d.st       = PWDATA_IN[0] ? ST_OP_RD : ST_IDLE;
            r_d.pc       = r_q.start;
            r_d.sp       = 3'h0;
            r_d.mem_req  = PWDATA_IN[0];
            r_d.mem_we   = 1'b0;
            r_d.mem_addr = r_q.start;
        end
        r_d.halted = (r_d.st == ST_HALT);
        // Hardware set wins over software clear
        r_d.int_st = r_d.int_st | (ev & r_q.int_en);
        r_d.irq    = |r_d.int_st;
    end

    always_ff @(posedge CLOCK_IN)
    begin
        if (!RSTN_IN)
        begin
            r_q       <= '0;
            r_q.st    <= ST_IDLE;
            r_q.start <= START_RST;
            r_q.qptr  <= QPTR_RST;
        end
        else
            r_q <= r_d;
    end

    assign PRDATA_OUT          = r_q.prdata;
    assign PREADY_OUT          = r_q.pready;
    assign PSLVERR_OUT         = r_q.pslverr;
    assign MEM_REQ_OUT         = r_q.mem_req;
    assign MEM_WE_OUT          = r_q.mem_we;
    assign MEM_ADDR_OUT        = r_q.mem_addr;
    assign MEM_WDATA_OUT       = r_q.mem_wdata;
    assign MSG_START_OUT       = r_q.msg_start;
    assign MSG_PTR_OUT         = r_q.prm;
    assign TIME_TAG_LOAD_OUT   = r_q.tt_load;
    assign FRAME_TIME_LOAD_OUT = r_q.ft_load;
    assign FRAME_START_OUT     = r_q.frm_start;
    assign HALTED_OUT          = r_q.halted;
    assign IRQ_OUT             = r_q.irq;

    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    chk_bad_fetch_halt: assert property (
        r_q.st == ST_OP_RD && MEM_ACK_IN && !op_ok
        |=> r_q.st == ST_HALT && HALTED_OUT ##1 !MEM_REQ_OUT)
        else $error("invalid op code did not halt");
    chk_trap_irq: assert property (
        r_q.st == ST_OP_RD && MEM_ACK_IN && !op_ok && r_q.int_en[INT_TRAP]
        |=> r_q.int_st[INT_TRAP] ##1 IRQ_OUT)
        else $error("trap interrupt missing");
    chk_parity_irq: assert property (
        r_q.st == ST_OP_RD && MEM_ACK_IN && !parity_ok
        && r_q.int_en[INT_PARITY] |=> r_q.int_st[INT_PARITY])
        else $error("parity interrupt missing");
    chk_halt_no_fetch: assert property (
        r_q.st == ST_HALT && !(apb_wr && PADDR_IN == REG_CTRL)
        |=> !MEM_REQ_OUT)
        else $error("fetch while halted");
    chk_stack_depth: assert property (
        r_q.sp <= 3'(STACK_DEPTH))
        else $error("call stack pointer out of range");
    chk_flip_value: assert property (
        r_q.st == ST_FLIP_CHK && cond_true
        |=> MEM_WE_OUT && MEM_WDATA_OUT == ($past(r_q.prm) ^ FLIP_MASK)
            && MEM_ADDR_OUT == $past(r_q.pc) + 16'h0001)
        else $error("flip write wrong");
    chk_queue_step: assert property (
        r_q.st == ST_MEM_WR && MEM_ACK_IN && r_q.push && !apb_wr
        |=> r_q.qptr[5:0] == $past(r_q.qptr[5:0]) + 6'h01
            && r_q.qptr[15:6] == $past(r_q.qptr[15:6]))
        else $error("queue pointer step wrong");
    chk_queue_roll: assert property (
        r_q.st == ST_MEM_WR && MEM_ACK_IN && r_q.push
        && r_q.qptr[5:0] == QUEUE_WRAP && r_q.int_en[INT_QROLL]
        |=> r_q.int_st[INT_QROLL] && r_q.qptr[5:0] == 6'h00)
        else $error("queue rollover missed");
    chk_retry_code: assert property (
        r_q.retry != 2'b10)
        else $error("unused retry code seen");
    chk_flip_message: assert property (
        r_q.st == ST_EXEC && r_q.op[OP_CODE_LSB +: 5] == OPC_FLIP
        |=> MSG_START_OUT && MSG_PTR_OUT == $past(r_q.prm))
        else $error("execute-and-flip skipped its message");

    cov_flip: cover property (r_q.st == ST_FLIP_CHK && cond_true);
    cov_trap: cover property (r_q.st == ST_OP_RD && MEM_ACK_IN && !op_ok);
    cov_roll: cover property (ev[INT_QROLL]);
    cov_stack_err: cover property (ev[INT_STACK]);

endmodule : bcs_engine

`default_nettype wire

// ==== verification/bcs_ram_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module bcs_ram_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    // Engine side
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [15:0] wdata_in,
    output logic [15:0]      rdata_out,
    output logic             ack_out
);
    logic [15:0] mem [0:255];
    // Read data is scrambled outside the ack cycle
    always @(posedge clk_in)
        if (rstn_in && req_in && !ack_out)
        begin
            ack_out <= 1'b1;
            rdata_out <= mem[addr_in[7:0]];
            if (we_in) mem[addr_in[7:0]] <= wdata_in;
        end
        else
        begin
            ack_out <= 1'b0;
            rdata_out <= rstn_in ? ~rdata_out : 16'h0000;
        end
endmodule : bcs_ram_model
`default_nettype wire

// ==== verification/bcs_engine_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module bcs_engine_tb;
    import bcs_pkg::*;
    typedef struct { logic [7:0] a; logic [31:0] m, e; } bcs_row_t;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, pready, perr, err;
    logic mreq, mwe, mack, mstart, done = 0, seen = 0, halted, irq;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] maddr, mwdata, mrdata, mptr, ptr_seen, tt = 0;
    int failures = 0, tests_run = 0, cyc = 0;
    bcs_row_t rows [4] = '{'{REG_QPTR, 32'hffff, 32'h80},
        '{REG_FLAGS, 32'hff, 32'hf}, '{REG_INT_ST, 32'h1f, 32'h18},
        '{REG_STATUS, 32'h8f00, 32'h8500}};
    always #2 clk = ~clk;
    always @(posedge clk) tt <= tt + 16'h0001;
    always @(negedge clk) seen = mstart;
    always @(negedge clk) if (mstart) ptr_seen = mptr;
    always @(posedge clk) done <= seen;
    bcs_engine dut_u (.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(perr), .MEM_REQ_OUT(mreq), .MEM_WE_OUT(mwe),
        .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwdata), .MEM_RDATA_IN(mrdata),
        .MEM_ACK_IN(mack), .MSG_START_OUT(mstart), .MSG_PTR_OUT(mptr),
        .MSG_DONE_IN(done), .MSG_FMT_ERR_IN(tt[0]), .MSG_LOOP_FAIL_IN(tt[1]),
        .MSG_NORESP_IN(tt[2]), .MSG_GOOD_BLK_IN(tt[3]),
        .MSG_MASKED_IN(tt[4]), .MSG_RETRIES_IN(tt[6:5]),
        .MSG_BLK_STATUS_IN(tt), .TIME_TAG_IN(tt), .FRAME_TIME_IN(tt),
        .NEXT_MSG_TIME_IN(tt), .EXT_TRIG_IN(tt[7]), .TIME_TAG_LOAD_OUT(),
        .FRAME_TIME_LOAD_OUT(), .FRAME_START_OUT(), .HALTED_OUT(halted),
        .IRQ_OUT(irq));
    bcs_ram_model ram_u (.clk_in(clk), .rstn_in(rstn), .req_in(mreq),
        .we_in(mwe), .addr_in(maddr), .wdata_in(mwdata), .rdata_out(mrdata),
        .ack_out(mack));
    function automatic logic [15:0] op(input logic [4:0] c, input logic n);
        logic [14:0] w;
        w = {c, OP_SIGNATURE, n, 4'hf};
        return {~^w, w};
    endfunction : op
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Request held until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = perr;
        {psel, pen} <= 2'b00;
    endtask : apb
    task automatic run;
        apb(1, REG_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        while (halted !== 1'b1) @(posedge clk);
    endtask : run
    task automatic summarize;
        $display("Counts: %0d checks, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            summarize();
        end
    end
    initial
    begin
        ram_u.mem[0:11] = '{op(OPC_PIMM, 0), 16'h1234, op(OPC_PIMM, 1),
            16'h0001, op(OPC_FLAG, 0), 16'h000f, op(OPC_IRQ, 0), 16'h0005,
            op(OPC_FLIP, 0), 16'h0040, op(OPC_HALT, 0), 16'h0000};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        apb(1, REG_INT_EN, 32'h1f);
        // Queue sits on its last slot so the first push rolls over
        apb(1, REG_QPTR, 32'hbf);
        run();
        foreach (rows[i])
        begin
            apb(0, rows[i].a, 0);
            chk(rd & rows[i].m, rows[i].e);
        end
        chk(ram_u.mem[8'hbf], 16'h1234);
        chk(ptr_seen, 16'h0040);
        chk(ram_u.mem[9], 16'h0050);
        chk(irq, 1'b1);
        run();
        chk(ptr_seen, 16'h0050);
        chk(ram_u.mem[9], 16'h0040);
        $display("Program test done");
        apb(1, REG_INT_ST, 32'h1f);
        ram_u.mem[0] = op(OPC_PIMM, 0) ^ 16'h8000;
        run();
        apb(0, REG_INT_ST, 0);
        chk(rd, 32'h3);
        apb(0, REG_QPTR, 0);
        chk(rd, 32'h81);
        apb(0, 8'h3c, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        apb(0, REG_QPTR, 0);
        chk(rd, {16'h0000, QPTR_RST});
        $display("Fault and reset test done");
        summarize();
    end
endmodule : bcs_engine_tb
`default_nettype wire
